// *** rtl/ili_interlock.sv ***
// Issue interlock: scoreboard, stage locks, neighbour adjustments, prefetch.
// Assumes a decoder presenting one descriptor per cycle and a fetch bus.
// Summary of operation
// - Each destination register gets its own latency
// - Conditional branch target fetched after 2, or 1
// - Double ops: pair halves and status separately
// - Transform latencies 5,5,6,7/8, two stage locks
// - Memory MAC: four separate destination latencies
// - Register multiply: high, low latencies apart
// - Stage lock spans start cycle, listed count
// - FP result then store/transfer: one less
// - Load feeding dynamic shift: one more
// - Short load/store before double ops: three
// - Multiply then accumulator store: five
// - Back to back multiplies: two
// - Accumulator load then store: four
// - Accumulator load then multiply: one
// - Swap then FP load/store: not paired
// - Truncate then transfer move: one
// - Prefetch runs at most 20 bytes ahead
`timescale 1ns/100ps
module ili_interlock
	import ili_pkg::*;
#(
	parameter int NREG = 2 ** IDX_W
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Decode side
	input wire ili_instr_t instr,
	output logic issue,
	// Fetch side
	input wire logic pf_ack,
	output logic pf_req,
	output logic [31:0] pf_addr,
	output logic target_fetch
);

	logic [4:0] cnt_q [NREG];
	logic [RES_W-1:0] res_q [NSTAGE];
	ili_instr_t prev_q;
	logic prev_vld_q;
	logic [4:0] elapsed_q;
	logic [4:0] br_cnt_q;
	logic [31:0] br_tgt_q;
	logic [31:0] pf_addr_q;
	logic [4:0] lead_q;

	// Fixed figures that override the decoder's fields
	function automatic ili_instr_t apply_tbl(ili_instr_t i);
		apply_tbl = i;
		if (i.matrix_vector_transform)
		begin
			apply_tbl.dst[0].lat = MATRIX_VECTOR_TRANSFORM_LAT0;
			apply_tbl.dst[1].lat = MATRIX_VECTOR_TRANSFORM_LAT1;
			apply_tbl.dst[2].lat = MATRIX_VECTOR_TRANSFORM_LAT2;
			apply_tbl.dst[3].lat = MATRIX_VECTOR_TRANSFORM_LAT3;
			apply_tbl.dst[4].lat = MATRIX_VECTOR_TRANSFORM_LAT_ST;
			apply_tbl.lock[0] = '{1'b1, ST_F0, MATRIX_VECTOR_TRANSFORM_F0_START, MATRIX_VECTOR_TRANSFORM_LOCK_CYC};
			apply_tbl.lock[1] = '{1'b1, ST_F1, MATRIX_VECTOR_TRANSFORM_F1_START, MATRIX_VECTOR_TRANSFORM_LOCK_CYC};
		end
	endfunction

	// Latency of the previous instruction as seen by the current one
	function automatic logic [4:0] adj_lat(ili_instr_t p, ili_instr_t c,
		logic [4:0] b);
		logic pm;
		logic cm;
		pm = p.op inside {OP_MUL, OP_MAC_MEM};
		cm = c.op inside {OP_MUL, OP_MAC_MEM};
		if (p.op == OP_FLOAT_TRUNCATE_OP_S && c.op == OP_STS_FLOAT_INTEGER_TRANSFER_REG)
			adj_lat = FLOAT_TRUNCATE_OP_FLOAT_INTEGER_TRANSFER_REG_LAT;
		else if (pm && c.op == OP_STS_MAC_DEC)
			adj_lat = MUL_STS_LAT;
		else if (p.op == OP_LDS_MAC && c.op == OP_STS_MAC_DEC)
			adj_lat = LDS_STS_LAT;
		else if (pm && cm)
			adj_lat = MUL_B2B_LAT;
		else if (p.op == OP_LDS_MAC && cm)
			adj_lat = LDS_MUL_LAT;
		else if (p.ls_grp && b < LS_MIN_LAT
			&& (c.op inside {OP_FP_DBL, OP_INNER_PRODUCT_OP_MATRIX_VECTOR_TRANSFORM} || c.matrix_vector_transform))
			adj_lat = LS_MIN_LAT;
		else if (p.op == OP_FP_COMP && b != 5'h00
			&& c.op inside {OP_FP_STORE, OP_STS_FLOAT_INTEGER_TRANSFER_REG, OP_STS_FLOAT_INTEGER_TRANSFER_REG_DEC})
			adj_lat = b - FP_DEC;
		else if (p.op == OP_LOAD && c.op == OP_SHIFT_DYN)
			adj_lat = b + SHIFT_INC;
		else
			adj_lat = b;
	endfunction

	// Source ready test; adjacency only against the previous issue.
	// Every input is an argument, so the continuous assignment that calls it
	// re-evaluates whenever a counter or the previous-issue state moves.
	function automatic logic src_ready(
		ili_src_t s,
		logic [4:0] cnt,
		ili_instr_t p,
		logic pv,
		logic [4:0] el,
		ili_instr_t c
	);
		logic r;
		r = cnt == CNT_RST;
		if (pv)
		begin
			for (int k = 0; k < NDST; k++)
			begin
				if (p.dst[k].en && p.dst[k].idx == s.idx)
					r = el >= adj_lat(p, c, p.dst[k].lat);
			end
		end
		src_ready = !s.en || r;
	endfunction

	// Busy window of a lock, bit 0 being the issue cycle
	function automatic logic [RES_W-1:0] lock_win(ili_lock_t l);
		logic [RES_W-1:0] m;
		m = (RES_W'(1) << l.cycles) - RES_W'(1);
		lock_win = l.en ? m << (l.start - 5'h01) : '0;
	endfunction

	wire ili_instr_t eff = apply_tbl(instr);
	wire [RES_W-1:0] win0 = lock_win(eff.lock[0]);
	wire [RES_W-1:0] win1 = lock_win(eff.lock[1]);
	wire [4:0] cnt_s0 = cnt_q[instr.src[0].idx];
	wire [4:0] cnt_s1 = cnt_q[instr.src[1].idx];
	wire src_ok0 = src_ready(instr.src[0], cnt_s0, prev_q, prev_vld_q, elapsed_q, instr);
	wire src_ok1 = src_ready(instr.src[1], cnt_s1, prev_q, prev_vld_q, elapsed_q, instr);
	wire src_ok = src_ok0 && src_ok1;
	wire lock_ok = ((res_q[eff.lock[0].stage] & win0)
		| (res_q[eff.lock[1].stage] & win1)) == '0;
	wire swap_hold = prev_vld_q && prev_q.swap && elapsed_q < SWAP_GAP
		&& instr.ls_grp && instr.fp_acc;
	wire is_br = instr.op inside {OP_BR, OP_BR_COND};
	wire [4:0] br_lat = instr.op == OP_BR ? instr.dst[0].lat
		: (instr.disp_zero ? BR_LAT_Z : BR_LAT_NZ);
	wire [4:0] lead_add = (pf_req && pf_ack) ? FETCH_BYTES : 5'h00;
	wire [4:0] lead_sub = (issue && lead_q >= INSTR_BYTES) ? INSTR_BYTES : 5'h00;

	assign issue = instr.valid && src_ok && lock_ok && !swap_hold;
	assign target_fetch = br_cnt_q == 5'h01;
	assign pf_req = !target_fetch && lead_q + FETCH_BYTES <= PF_AHEAD;
	assign pf_addr = pf_addr_q;

	// Per-register countdown, loaded with its destination's latency less one (the largest if several hit)
	genvar g;
	generate
		for (g = 0; g < NREG; g++)
		begin : g_sb
			localparam logic [IDX_W-1:0] GI = IDX_W'(g);
			logic hit;
			logic [4:0] ld;
			always_comb
			begin
				hit = 1'b0;
				ld = 5'h00;
				for (int k = 0; k < NDST; k++)
				begin
					if (issue && eff.dst[k].en && eff.dst[k].idx == GI)
					begin
						hit = 1'b1;
						if (eff.dst[k].lat > ld)
							ld = eff.dst[k].lat;
					end
				end
			end
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					cnt_q[g] <= CNT_RST;
				else if (hit)
					cnt_q[g] <= ld == 5'h00 ? 5'h00 : ld - 5'h01;
				else if (cnt_q[g] != CNT_RST)
					cnt_q[g] <= cnt_q[g] - 5'h01;
			end
		end
		// Stage reservations shift toward bit 0 every cycle
		for (g = 0; g < NSTAGE; g++)
		begin : g_st
			localparam logic [1:0] GS = 2'(g);
			wire [RES_W-1:0] add0 = (issue && eff.lock[0].stage == GS) ? win0 : '0;
			wire [RES_W-1:0] add1 = (issue && eff.lock[1].stage == GS) ? win1 : '0;
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					res_q[g] <= '0;
				else
					res_q[g] <= (res_q[g] >> 1) | ((add0 | add1) >> 1);
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_q <= '0;
			prev_vld_q <= 1'b0;
			elapsed_q <= CNT_RST;
		end
		else if (issue)
		begin
			prev_q <= eff;
			prev_vld_q <= 1'b1;
			elapsed_q <= 5'h01;
		end
		else if (elapsed_q != ELAPSED_MAX)
			elapsed_q <= elapsed_q + 5'h01;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			br_cnt_q <= CNT_RST;
			br_tgt_q <= PF_RST_ADDR;
		end
		else if (issue && is_br)
		begin
			br_cnt_q <= br_lat;
			br_tgt_q <= instr.target;
		end
		else if (br_cnt_q != CNT_RST)
			br_cnt_q <= br_cnt_q - 5'h01;
	end

	// Prefetch pointer and the bytes held ahead of execution
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pf_addr_q <= PF_RST_ADDR;
			lead_q <= CNT_RST;
		end
		else if (target_fetch)
		begin
			pf_addr_q <= br_tgt_q;
			lead_q <= CNT_RST;
		end
		else
		begin
			if (pf_req && pf_ack)
				pf_addr_q <= pf_addr_q + 32'(FETCH_BYTES);
			lead_q <= lead_q + lead_add - lead_sub;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	wire adj_pre = prev_vld_q && instr.valid && prev_q.dst[0].en;
	wire [4:0] adj0 = adj_lat(prev_q, instr, prev_q.dst[0].lat);
	wire [4:0] base0 = prev_q.dst[0].lat;

	sequence s_fetch_after2;
		!target_fetch ##1 target_fetch;
	endsequence

	// A consumer of the last issue's first result may not beat its adjusted latency
	a_src_stall: assert property (issue && adj_pre && instr.src[0].en
		&& instr.src[0].idx == prev_q.dst[0].idx |-> elapsed_q >= adj0)
		else $error("issued with a source not ready");
	// A lock claimed in the issue cycle needs that stage free now
	a_lock_stall: assert property (issue && eff.lock[0].en && eff.lock[0].start == 5'h01
		&& eff.lock[0].cycles != 5'h00 |-> !res_q[eff.lock[0].stage][0])
		else $error("issued into a locked stage");
	// No FP load/store in the cycle right after a swap
	a_swap_split: assert property (issue && $past(issue) && $past(instr.swap)
		|-> !(instr.ls_grp && instr.fp_acc))
		else $error("FP load/store paired with swap");
	a_br_zero: assert property (issue && instr.op == OP_BR_COND && instr.disp_zero
		|=> target_fetch)
		else $error("zero displacement branch not one cycle");
	a_br_nonzero: assert property (issue && instr.op == OP_BR_COND && !instr.disp_zero
		|=> s_fetch_after2)
		else $error("branch target fetch not at two cycles");
	a_matrix_vector_transform_lock: assert property (issue && instr.matrix_vector_transform
		|=> res_q[0][3:0] == 4'hf && res_q[1][4:0] == 5'h1e)
		else $error("transform stage locks wrong");
	a_matrix_vector_transform_lat: assert property (issue && instr.matrix_vector_transform && eff.dst[3].en
		|=> cnt_q[$past(eff.dst[3].idx)] == 5'h06)
		else $error("transform fourth latency wrong");
	a_fp_dec: assert property (adj_pre && prev_q.op == OP_FP_COMP
		&& instr.op == OP_FP_STORE && base0 != 5'h00 |-> adj0 == base0 - 5'h01)
		else $error("FP store reduction missing");
	a_shift_inc: assert property (adj_pre && prev_q.op == OP_LOAD
		&& instr.op == OP_SHIFT_DYN |-> adj0 == base0 + 5'h01)
		else $error("shift load increase missing");
	a_mul_adj: assert property (adj_pre && prev_q.op == OP_MUL
		|-> (instr.op == OP_STS_MAC_DEC ? adj0 == 5'h05
		: instr.op != OP_MUL || adj0 == 5'h02))
		else $error("multiply neighbour latency wrong");
	a_lds_adj: assert property (adj_pre && prev_q.op == OP_LDS_MAC
		|-> (instr.op == OP_STS_MAC_DEC ? adj0 == 5'h04
		: instr.op != OP_MAC_MEM || adj0 == 5'h01))
		else $error("accumulator load latency wrong");
	a_float_truncate_op_float_integer_transfer_reg: assert property (adj_pre && prev_q.op == OP_FLOAT_TRUNCATE_OP_S
		&& instr.op == OP_STS_FLOAT_INTEGER_TRANSFER_REG |-> adj0 == 5'h01)
		else $error("truncate transfer latency wrong");
	a_pf_window: assert property (lead_q <= PF_AHEAD)
		else $error("prefetch beyond window");

endmodule // ili_interlock

// *** shared/ili_pkg.sv ***
// Types and constants for the issue and latency interlock.
// Assumes a decoder that fills one descriptor per instruction.
package ili_pkg;

	localparam int IDX_W = 6;
	localparam int NDST = 5;
	localparam int RES_W = 32;
	localparam int NSTAGE = 4;

	typedef enum logic [3:0] {
		OP_GEN, OP_LOAD, OP_BR, OP_BR_COND, OP_FP_COMP, OP_FP_DBL,
		OP_FP_STORE, OP_STS_FLOAT_INTEGER_TRANSFER_REG, OP_STS_FLOAT_INTEGER_TRANSFER_REG_DEC, OP_SHIFT_DYN,
		OP_MUL, OP_MAC_MEM, OP_LDS_MAC, OP_STS_MAC_DEC, OP_FLOAT_TRUNCATE_OP_S,
		OP_INNER_PRODUCT_OP_MATRIX_VECTOR_TRANSFORM
	} ili_op_t;

	typedef struct packed {
		logic en;
		logic [IDX_W-1:0] idx;
	} ili_src_t;

	typedef struct packed {
		logic en;
		logic [IDX_W-1:0] idx;
		logic [4:0] lat;
	} ili_dst_t;

	typedef struct packed {
		logic en;
		logic [1:0] stage;
		logic [4:0] start;
		logic [4:0] cycles;
	} ili_lock_t;

	typedef struct packed {
		logic valid;
		ili_op_t op;
		logic matrix_vector_transform;
		logic ls_grp;
		logic fp_acc;
		logic swap;
		logic disp_zero;
		logic [31:0] target;
		ili_src_t [1:0] src;
		ili_dst_t [NDST-1:0] dst;
		ili_lock_t [1:0] lock;
	} ili_instr_t;

	// Stage numbers
	localparam logic [1:0] ST_F0 = 2'h0;
	localparam logic [1:0] ST_F1 = 2'h1;

	// Latency figures
	localparam logic [4:0] BR_LAT_NZ = 5'h02;
	localparam logic [4:0] BR_LAT_Z = 5'h01;
	localparam logic [4:0] MATRIX_VECTOR_TRANSFORM_LAT0 = 5'h05;
	localparam logic [4:0] MATRIX_VECTOR_TRANSFORM_LAT1 = 5'h05;
	localparam logic [4:0] MATRIX_VECTOR_TRANSFORM_LAT2 = 5'h06;
	localparam logic [4:0] MATRIX_VECTOR_TRANSFORM_LAT3 = 5'h07;
	localparam logic [4:0] MATRIX_VECTOR_TRANSFORM_LAT_ST = 5'h08;
	localparam logic [4:0] MATRIX_VECTOR_TRANSFORM_F0_START = 5'h02;
	localparam logic [4:0] MATRIX_VECTOR_TRANSFORM_F1_START = 5'h03;
	localparam logic [4:0] MATRIX_VECTOR_TRANSFORM_LOCK_CYC = 5'h04;
	localparam logic [4:0] FP_DEC = 5'h01;
	localparam logic [4:0] SHIFT_INC = 5'h01;
	localparam logic [4:0] LS_MIN_LAT = 5'h03;
	localparam logic [4:0] MUL_STS_LAT = 5'h05;
	localparam logic [4:0] MUL_B2B_LAT = 5'h02;
	localparam logic [4:0] LDS_STS_LAT = 5'h04;
	localparam logic [4:0] LDS_MUL_LAT = 5'h01;
	localparam logic [4:0] FLOAT_TRUNCATE_OP_FLOAT_INTEGER_TRANSFER_REG_LAT = 5'h01;
	localparam logic [4:0] SWAP_GAP = 5'h02;
	localparam logic [4:0] ELAPSED_MAX = 5'h1f;

	// Prefetch window, in bytes
	localparam logic [4:0] PF_AHEAD = 5'h14;
	localparam logic [4:0] FETCH_BYTES = 5'h04;
	localparam logic [4:0] INSTR_BYTES = 5'h02;

	// Values after reset
	localparam logic [31:0] PF_RST_ADDR = 32'h0000_0000;
	localparam logic [4:0] CNT_RST = 5'h00;

endpackage

// *** verif/ili_interlock_tb.sv ***
// Testbench for the issue interlock: latencies, stage locks, branches, prefetch.
// Assumes the interlock alone; the bench plays decoder and fetch bus itself.
`timescale 1ns/100ps
module ili_interlock_tb
	import ili_pkg::*;
	;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	ili_instr_t instr = '0;
	logic pf_ack = 1'b0;
	logic issue;
	logic pf_req;
	logic target_fetch;
	logic [31:0] pf_addr;
	int bad_count = 0;
	int comparisons = 0;
	int matrix_vector_transform_lat [NDST] = '{5, 5, 6, 7, 8};

	always #10 clk = ~clk;

	ili_interlock ili_interlock_inst (.clk(clk), .rst_n(rst_n), .instr(instr), .issue(issue),
		.pf_ack(pf_ack), .pf_req(pf_req), .pf_addr(pf_addr), .target_fetch(target_fetch));

	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
		end
	endtask

	task results;
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Index 0 means the operand is not used
	function automatic ili_instr_t mk(ili_op_t op, int didx, int dlat, int sidx);
		ili_instr_t d;
		d = '0;
		d.valid = 1'b1;
		d.op = op;
		d.dst[0] = '{didx != 0, didx[IDX_W-1:0], dlat[4:0]};
		d.src[0] = '{sidx != 0, sidx[IDX_W-1:0]};
		return d;
	endfunction

	// Presents a descriptor, counts stall cycles, returns at the edge that takes it
	task automatic send(input ili_instr_t d, output int w);
		instr <= d;
		w = 0;
		#1;
		while (issue !== 1'b1 && w < 40)
		begin
			@(posedge clk);
			#1;
			w++;
		end
		@(posedge clk);
	endtask

	task idle(input int n);
		instr <= '0;
		repeat (n) @(posedge clk);
	endtask

	task automatic t_pair(ili_op_t p, logic ls, int lat, ili_op_t c, int exp);
		ili_instr_t d;
		int w;
		d = mk(p, 1, lat, 0);
		d.ls_grp = ls;
		send(d, w);
		send(mk(c, 0, 0, 1), w);
		chk(w, exp - 1, "adjacent latency");
		idle(12);
	endtask

	task automatic t_multi;
		ili_instr_t d;
		int w;
		d = mk(OP_MAC_MEM, 1, 2, 0);
		d.dst[1] = '{1'b1, 6'h02, 5'h05};
		send(d, w);
		send(mk(OP_GEN, 0, 0, 2), w);
		chk(w, 4, "second destination");
		send(mk(OP_MUL, 1, 4, 0), w);
		send(mk(OP_GEN, 0, 0, 0), w);
		send(mk(OP_MUL, 0, 0, 1), w);
		chk(w, 2, "non-adjacent latency");
		idle(12);
	endtask

	task automatic t_matrix_vector_transform(input ili_instr_t probe, input int exp);
		ili_instr_t d;
		int w;
		d = mk(OP_INNER_PRODUCT_OP_MATRIX_VECTOR_TRANSFORM, 0, 0, 0);
		d.matrix_vector_transform = 1'b1;
		for (int i = 0; i < NDST; i++)
			d.dst[i] = '{1'b1, 6'(10 + i), 5'h01};
		send(d, w);
		send(probe, w);
		chk(w, exp, "transform timing");
		idle(14);
	endtask

	task automatic t_branch(input ili_op_t op, input logic z, input int lat);
		ili_instr_t d;
		int w;
		d = mk(op, 63, lat, 0);
		d.disp_zero = z;
		d.target = 32'h0000_1000 << lat;
		send(d, w);
		instr <= '0;
		for (int c = 1; c <= lat + 1; c++)
		begin
			#1;
			chk(target_fetch, c == lat, "target fetch pulse");
			if (c == lat)
				chk(pf_req, 1'b0, "prefetch during redirect");
			if (c == lat + 1)
				chk(pf_addr, d.target, "redirect address");
			@(posedge clk);
		end
		idle(4);
	endtask

	task automatic t_swap(input logic fp, input int exp);
		ili_instr_t d;
		int w;
		d = mk(OP_GEN, 0, 0, 0);
		d.swap = 1'b1;
		send(d, w);
		d = mk(OP_LOAD, 0, 0, 0);
		d.ls_grp = 1'b1;
		d.fp_acc = fp;
		send(d, w);
		chk(w, exp, "issue after swap");
		idle(4);
	endtask

	task automatic t_prefetch;
		int n;
		int w;
		n = 0;
		pf_ack <= 1'b1;
		#1;
		while (pf_req === 1'b1 && n < 10)
		begin
			n++;
			@(posedge clk);
			#1;
		end
		chk(n, 5, "fetches to fill window");
		chk(pf_addr, 32'h0000_0014, "address at full window");
		@(posedge clk);
		pf_ack <= 1'b0;
		send(mk(OP_GEN, 0, 0, 0), w);
		send(mk(OP_GEN, 0, 0, 0), w);
		#1;
		chk(pf_req, 1'b1, "window reopened");
		@(posedge clk);
		idle(2);
	endtask

	initial
	begin
		ili_instr_t p;
		repeat (2) @(posedge clk);
		chk(pf_req, 1'b1, "prefetch in reset");
		chk(pf_addr, 32'h0, "address in reset");
		rst_n <= 1'b1;
		@(posedge clk);
		t_prefetch;
		t_pair(OP_GEN, 1'b0, 4, OP_GEN, 4);
		t_pair(OP_FP_COMP, 1'b0, 3, OP_FP_STORE, 2);
		t_pair(OP_FP_COMP, 1'b0, 3, OP_STS_FLOAT_INTEGER_TRANSFER_REG, 2);
		t_pair(OP_FP_COMP, 1'b0, 3, OP_STS_FLOAT_INTEGER_TRANSFER_REG_DEC, 2);
		t_pair(OP_LOAD, 1'b0, 2, OP_SHIFT_DYN, 3);
		t_pair(OP_LOAD, 1'b1, 1, OP_FP_DBL, 3);
		t_pair(OP_LOAD, 1'b1, 2, OP_INNER_PRODUCT_OP_MATRIX_VECTOR_TRANSFORM, 3);
		t_pair(OP_MUL, 1'b0, 4, OP_STS_MAC_DEC, 5);
		t_pair(OP_MUL, 1'b0, 4, OP_MUL, 2);
		t_pair(OP_MAC_MEM, 1'b0, 4, OP_MUL, 2);
		t_pair(OP_LDS_MAC, 1'b0, 3, OP_STS_MAC_DEC, 4);
		t_pair(OP_LDS_MAC, 1'b0, 3, OP_MUL, 1);
		t_pair(OP_FLOAT_TRUNCATE_OP_S, 1'b0, 3, OP_STS_FLOAT_INTEGER_TRANSFER_REG, 1);
		t_multi;
		for (int i = 0; i < NDST; i++)
			t_matrix_vector_transform(mk(OP_GEN, 0, 0, 10 + i), matrix_vector_transform_lat[i] - 1);
		p = mk(OP_GEN, 0, 0, 0);
		p.lock[0] = '{1'b1, ST_F0, 5'h01, 5'h01};
		t_matrix_vector_transform(p, 4);
		p.lock[0] = '{1'b1, ST_F1, 5'h01, 5'h02};
		t_matrix_vector_transform(p, 5);
		t_branch(OP_BR_COND, 1'b1, 1);
		t_branch(OP_BR_COND, 1'b0, 2);
		t_branch(OP_BR, 1'b0, 3);
		t_swap(1'b1, 1);
		t_swap(1'b0, 0);
		results;
	end

	// The sequence needs well under a thousand cycles; this allows 5000
	initial
	begin
		#100000;
		bad_count++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		results;
	end
endmodule // ili_interlock_tb
